// ===== hdl/msr_pkg.sv
// Shared constants and types for the mission status register bank
`default_nettype none

package msr_pkg;

    // Register byte addresses
    localparam logic [15:0] ALARM_FLAGS_ADDR      = 16'h0214;
    localparam logic [15:0] MISSION_STATE_ADDR    = 16'h0215;
    localparam logic [15:0] START_DELAY_ADDR      = 16'h0216;
    localparam logic [15:0] FIRST_SAMPLE_ADDR     = 16'h0219;
    localparam logic [15:0] SAMPLE_COUNT_ADDR     = 16'h0220;

    // Field widths and byte counts
    localparam int          DELAY_WIDTH           = 24;
    localparam int          COUNT_WIDTH           = 24;
    localparam int          DELAY_BYTES           = 3;
    localparam int          COUNT_BYTES           = 3;
    localparam int          STAMP_BYTES           = 6;

    // Alarm flags register layout
    localparam int          BATTERY_RESET_BIT     = 7;
    localparam int          HIGH_TEMP_BIT         = 1;
    localparam int          LOW_TEMP_BIT          = 0;
    localparam logic [7:0]  ALARM_FIXED_ONES      = 8'h70;

    // Mission state flags register layout
    localparam int          AWAITING_ALARM_BIT    = 4;
    localparam int          MEMORY_CLEARED_BIT    = 3;
    localparam int          MISSION_ACTIVE_BIT    = 1;
    localparam logic [7:0]  STATE_FIXED_ONES      = 8'hC0;

    // Reset values
    localparam logic [23:0] DELAY_RESET           = 24'h000000;
    localparam logic [23:0] COUNT_RESET           = 24'h000000;
    localparam logic [47:0] STAMP_RESET           = 48'h000000000000;
    localparam logic        BATTERY_RESET_INIT    = 1'b1;
    localparam logic [7:0]  UNMAPPED_READ         = 8'h00;

    // Mission phases
    typedef enum logic [1:0] {
        PHASE_IDLE,
        PHASE_DELAY,
        PHASE_WAIT_ALARM,
        PHASE_LOGGING
    } msr_phase_type;

endpackage : msr_pkg

`default_nettype wire

// ===== hdl/msr_delay_timer.sv
// Minute countdown from mission start to sampling or alarm testing
`default_nettype none

module msr_delay_timer #(
    parameter int WIDTH = 24
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Control
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] loadValue,
    input  wire logic             abort,
    input  wire logic             minuteTick,
    // Status
    output logic                  expired
);

    logic [WIDTH-1:0] count_q;
    logic             running_q;
    logic             expired_q;

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            count_q   <= '0;
            running_q <= 1'b0;
            expired_q <= 1'b0;
        end
        else
        begin
            expired_q <= 1'b0;
            if (abort)
            begin
                running_q <= 1'b0;
            end
            else if (load)
            begin
                count_q   <= loadValue;
                running_q <= (loadValue != '0);
                expired_q <= (loadValue == '0);
            end
            else if (running_q && minuteTick)
            begin
                count_q <= count_q - WIDTH'(1);
                if (count_q == WIDTH'(1))
                begin
                    running_q <= 1'b0;
                    expired_q <= 1'b1;
                end
            end
        end
    end

    assign expired = expired_q;

endmodule : msr_delay_timer

`default_nettype wire

// ===== hdl/msr_sample_counter.sv
// Unsigned wake-up counter with synchronous clear
`default_nettype none

module msr_sample_counter #(
    parameter int WIDTH = 24
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Control
    input  wire logic             clear,
    input  wire logic             increment,
    // Count
    output logic [WIDTH-1:0]      count
);

    logic [WIDTH-1:0] count_q;

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            count_q <= '0;
        end
        else if (clear)
        begin
            count_q <= '0;
        end
        else if (increment)
        begin
            count_q <= count_q + WIDTH'(1);
        end
    end

    assign count = count_q;

endmodule : msr_sample_counter

`default_nettype wire

// ===== hdl/msr_mission_status.sv
// Mission status, start delay, timestamp and sample count registers
//
// Notes on behaviour
// - Alarm flags read-only; bits 6-4 one, 3-2 zero
// - Clear memory clears all alarm flags together, except a temperature flag hit in the same cycle
// - Battery reset flag reads 1 after power-on
// - Battery alarm always on; temperature alarms need enables
// - High flag set on conversion at/above threshold
// - Low flag set on conversion at/below threshold
// - Forced conversion and triggering alarm set flags
// - State flags read-only; bits 7,6 one; 5,2,0 zero
// - Awaiting flag set on alarm-start; cleared by alarm
// - Awaiting flag survives clear memory and stop
// - Clear memory zeroes stamp, count, alarm flags; sets cleared
// - Memory-cleared flag drops when mission starts, unless clear memory comes in the same cycle
// - Mission starts only when memory was cleared
// - Mission-active flag high while mission runs
// - Delay bytes low-center-high, writable only between missions
// - Delay counts minutes to logging or alarm testing
// - Alarm-start waits full delay before testing
// - Timestamp captures time of first mission sample
// - Timestamp is BCD calendar with hour and century bits
// - Sample count read-only, low-center-high bytes
// - Sample count counts wake-ups, zeroed by clear
`default_nettype none

module msr_mission_status #(
    parameter int DELAY_WIDTH = msr_pkg::DELAY_WIDTH,
    parameter int COUNT_WIDTH = msr_pkg::COUNT_WIDTH
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Register access from the memory function logic
    input  wire logic [15:0] regAddr,
    input  wire logic        regRdEn,
    input  wire logic        regWrEn,
    input  wire logic [7:0]  regWrData,
    output logic [7:0]       regRdData,
    // Command events
    input  wire logic        clearMemoryCmd,
    input  wire logic        startMissionCmd,
    input  wire logic        stopMissionCmd,
    // Mission configuration
    input  wire logic        highAlarmEnable,
    input  wire logic        lowAlarmEnable,
    input  wire logic        alarm_triggered_start,
    // Conversion results and timebase
    input  wire logic        missionConvDone,
    input  wire logic        forcedConvDone,
    input  wire logic        convHighHit,
    input  wire logic        convLowHit,
    input  wire logic        minuteTick,
    input  wire logic [47:0] calendarNow,
    // Status to the rest of the logger
    output logic             mission_active_flag,
    output logic             awaiting_alarm_flag,
    output logic             memory_cleared_flag,
    output logic             battery_reset_flag,
    output logic             high_temp_flag,
    output logic             low_temp_flag,
    output logic             alarmTesting,
    output logic             loggingActive,
    output logic             startAccepted
);

    msr_pkg::msr_phase_type phase_q;

    logic                   missionActive_q;
    logic                   awaitingAlarm_q;
    logic                   memoryCleared_q;
    logic                   batteryReset_q;
    logic                   highTemp_q;
    logic                   lowTemp_q;
    logic                   firstPending_q;
    logic                   startAccepted_q;
    logic [7:0]             regRdData_q;
    logic [DELAY_WIDTH-1:0] startDelay_q;
    logic [47:0]            firstStamp_q;

    logic                   startOk;
    logic                   stopOk;
    logic                   clearOk;
    logic                   delayExpired;
    logic                   missionConv;
    logic                   highEvent;
    logic                   lowEvent;
    logic                   alarmEvent;
    logic                   triggerAlarm;
    logic                   loggedSample;
    logic [COUNT_WIDTH-1:0] sampleCount;
    logic [7:0]             alarmByte;
    logic [7:0]             stateByte;

    // Byte index of addr within a field starting at base, or -1
    function automatic int fieldIndex(
        input logic [15:0] addr,
        input logic [15:0] base,
        input int          bytes
    );
        int diff;
        diff = int'(addr) - int'(base);
        if (diff >= 0 && diff < bytes)
        begin
            return diff;
        end
        return -1;
    endfunction : fieldIndex

    // Command qualification
    assign startOk = startMissionCmd && memoryCleared_q
                     && !missionActive_q;
    assign stopOk  = stopMissionCmd && missionActive_q;
    // Clearing is refused while a mission runs
    assign clearOk = clearMemoryCmd && !missionActive_q;

    // Alarm events gated by their enables
    assign missionConv = missionConvDone
                         && (phase_q == msr_pkg::PHASE_WAIT_ALARM
                             || phase_q == msr_pkg::PHASE_LOGGING);
    assign highEvent   = (missionConv || forcedConvDone)
                         && convHighHit && highAlarmEnable;
    assign lowEvent    = (missionConv || forcedConvDone)
                         && convLowHit && lowAlarmEnable;
    assign alarmEvent  = highEvent || lowEvent;

    // Alarm that opens logging in alarm-start mode
    assign triggerAlarm = missionConv && alarmEvent
                          && phase_q == msr_pkg::PHASE_WAIT_ALARM;
    assign loggedSample = (missionConv
                           && phase_q == msr_pkg::PHASE_LOGGING)
                          || triggerAlarm;

    msr_delay_timer #(
        .WIDTH      (DELAY_WIDTH)
    ) u_delay_timer (
        .clk        (clk),
        .reset_n    (reset_n),
        .load       (startOk),
        .loadValue  (startDelay_q),
        .abort      (stopOk),
        .minuteTick (minuteTick),
        .expired    (delayExpired)
    );

    // Trigger sample is not counted as a wake-up
    msr_sample_counter #(
        .WIDTH      (COUNT_WIDTH)
    ) u_sample_counter (
        .clk        (clk),
        .reset_n    (reset_n),
        .clear      (clearOk),
        .increment  (missionConv
                     && phase_q == msr_pkg::PHASE_LOGGING),
        .count      (sampleCount)
    );

    // Mission phase sequencing
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            phase_q <= msr_pkg::PHASE_IDLE;
        end
        else if (stopOk)
        begin
            phase_q <= msr_pkg::PHASE_IDLE;
        end
        else
        begin
            unique case (phase_q)
                msr_pkg::PHASE_IDLE:
                begin
                    if (startOk)
                    begin
                        phase_q <= msr_pkg::PHASE_DELAY;
                    end
                end
                msr_pkg::PHASE_DELAY:
                begin
                    if (delayExpired)
                    begin
                        phase_q <= alarm_triggered_start
                                   ? msr_pkg::PHASE_WAIT_ALARM
                                   : msr_pkg::PHASE_LOGGING;
                    end
                end
                msr_pkg::PHASE_WAIT_ALARM:
                begin
                    if (triggerAlarm)
                    begin
                        phase_q <= msr_pkg::PHASE_LOGGING;
                    end
                end
                msr_pkg::PHASE_LOGGING:
                begin
                    phase_q <= msr_pkg::PHASE_LOGGING;
                end
            endcase
        end
    end

    // Mission active flag
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            missionActive_q <= 1'b0;
        end
        else if (startOk)
        begin
            missionActive_q <= 1'b1;
        end
        else if (stopOk)
        begin
            missionActive_q <= 1'b0;
        end
    end

    // Awaiting alarm flag; set wins over clear, clear memory ignored
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            awaitingAlarm_q <= 1'b0;
        end
        else if (startOk && alarm_triggered_start)
        begin
            awaitingAlarm_q <= 1'b1;
        end
        else if (alarmEvent)
        begin
            awaitingAlarm_q <= 1'b0;
        end
    end

    // Memory cleared flag
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            memoryCleared_q <= 1'b0;
        end
        else if (clearOk)
        begin
            memoryCleared_q <= 1'b1;
        end
        else if (startOk)
        begin
            memoryCleared_q <= 1'b0;
        end
    end

    // Battery reset flag, set by the power-on reset itself
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            batteryReset_q <= msr_pkg::BATTERY_RESET_INIT;
        end
        else if (clearOk)
        begin
            batteryReset_q <= 1'b0;
        end
    end

    // Temperature flags are sticky; a hit beats a clear
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            highTemp_q <= 1'b0;
            lowTemp_q  <= 1'b0;
        end
        else
        begin
            if (highEvent)
            begin
                highTemp_q <= 1'b1;
            end
            else if (clearOk)
            begin
                highTemp_q <= 1'b0;
            end
            if (lowEvent)
            begin
                lowTemp_q <= 1'b1;
            end
            else if (clearOk)
            begin
                lowTemp_q <= 1'b0;
            end
        end
    end

    // Timestamp of the first logged sample
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            firstStamp_q   <= msr_pkg::STAMP_RESET;
            firstPending_q <= 1'b0;
        end
        else if (clearOk)
        begin
            firstStamp_q   <= msr_pkg::STAMP_RESET;
            firstPending_q <= startOk;
        end
        else if (startOk)
        begin
            firstPending_q <= 1'b1;
        end
        else if (firstPending_q && loggedSample)
        begin
            firstStamp_q   <= calendarNow;
            firstPending_q <= 1'b0;
        end
    end

    // Start delay bytes, write-protected during a mission
    always_ff @(posedge clk)
    begin
        int idx;
        idx = fieldIndex(regAddr, msr_pkg::START_DELAY_ADDR,
                         msr_pkg::DELAY_BYTES);
        if (!reset_n)
        begin
            startDelay_q <= msr_pkg::DELAY_RESET;
        end
        else if (regWrEn && !missionActive_q && idx >= 0)
        begin
            startDelay_q[8*idx +: 8] <= regWrData;
        end
    end

    // Fixed bits of the two flag registers
    always_comb
    begin
        alarmByte = msr_pkg::ALARM_FIXED_ONES;
        alarmByte[msr_pkg::BATTERY_RESET_BIT] = batteryReset_q;
        alarmByte[msr_pkg::HIGH_TEMP_BIT]     = highTemp_q;
        alarmByte[msr_pkg::LOW_TEMP_BIT]      = lowTemp_q;
        stateByte = msr_pkg::STATE_FIXED_ONES;
        stateByte[msr_pkg::AWAITING_ALARM_BIT] = awaitingAlarm_q;
        stateByte[msr_pkg::MEMORY_CLEARED_BIT] = memoryCleared_q;
        stateByte[msr_pkg::MISSION_ACTIVE_BIT] = missionActive_q;
    end

    // Registered read data; unmapped bytes read zero
    always_ff @(posedge clk)
    begin
        int dIdx;
        int sIdx;
        int cIdx;
        dIdx = fieldIndex(regAddr, msr_pkg::START_DELAY_ADDR,
                          msr_pkg::DELAY_BYTES);
        sIdx = fieldIndex(regAddr, msr_pkg::FIRST_SAMPLE_ADDR,
                          msr_pkg::STAMP_BYTES);
        cIdx = fieldIndex(regAddr, msr_pkg::SAMPLE_COUNT_ADDR,
                          msr_pkg::COUNT_BYTES);
        if (!reset_n)
        begin
            regRdData_q <= msr_pkg::UNMAPPED_READ;
        end
        else if (regRdEn)
        begin
            if (regAddr == msr_pkg::ALARM_FLAGS_ADDR)
            begin
                regRdData_q <= alarmByte;
            end
            else if (regAddr == msr_pkg::MISSION_STATE_ADDR)
            begin
                regRdData_q <= stateByte;
            end
            else if (dIdx >= 0)
            begin
                regRdData_q <= startDelay_q[8*dIdx +: 8];
            end
            else if (sIdx >= 0)
            begin
                regRdData_q <= firstStamp_q[8*sIdx +: 8];
            end
            else if (cIdx >= 0)
            begin
                regRdData_q <= sampleCount[8*cIdx +: 8];
            end
            else
            begin
                regRdData_q <= msr_pkg::UNMAPPED_READ;
            end
        end
    end

    // One-cycle acknowledgement of an accepted start
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            startAccepted_q <= 1'b0;
        end
        else
        begin
            startAccepted_q <= startOk;
        end
    end

    // Phase-derived status outputs, registered
    logic alarmTesting_q;
    logic loggingActive_q;

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            alarmTesting_q  <= 1'b0;
            loggingActive_q <= 1'b0;
        end
        else
        begin
            alarmTesting_q  <= (phase_q == msr_pkg::PHASE_WAIT_ALARM);
            loggingActive_q <= (phase_q == msr_pkg::PHASE_LOGGING);
        end
    end

    assign regRdData           = regRdData_q;
    assign mission_active_flag = missionActive_q;
    assign awaiting_alarm_flag = awaitingAlarm_q;
    assign memory_cleared_flag = memoryCleared_q;
    assign battery_reset_flag  = batteryReset_q;
    assign high_temp_flag      = highTemp_q;
    assign low_temp_flag       = lowTemp_q;
    assign alarmTesting        = alarmTesting_q;
    assign loggingActive       = loggingActive_q;
    assign startAccepted       = startAccepted_q;

endmodule : msr_mission_status

`default_nettype wire

// ===== tb/msr_checker.sv
// Port assertions for the mission status register bank
`default_nettype none

module msr_checker (
    // Clock, reset and read port
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [15:0] regAddr,
    input  wire logic        regRdEn,
    input  wire logic [7:0]  regRdData,
    // Events
    input  wire logic        clearMemoryCmd,
    input  wire logic        startMissionCmd,
    input  wire logic        stopMissionCmd,
    input  wire logic        missionConvDone,
    input  wire logic        forcedConvDone,
    input  wire logic        convHighHit,
    input  wire logic        highAlarmEnable,
    // Flags
    input  wire logic        mission_active_flag,
    input  wire logic        awaiting_alarm_flag,
    input  wire logic        memory_cleared_flag,
    input  wire logic        battery_reset_flag,
    input  wire logic        high_temp_flag,
    input  wire logic        low_temp_flag,
    input  wire logic        startAccepted
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    alarm_fixed_a: assert property (
        regRdEn && regAddr == 16'h0214 |=> regRdData[6:2] == 5'h1C)
        else $error("alarm byte fixed bits wrong");
    state_fixed_a: assert property (
        regRdEn && regAddr == 16'h0215 |=>
        {regRdData[7:5], regRdData[2], regRdData[0]} == 5'h18)
        else $error("state byte fixed bits wrong");
    clear_effect_a: assert property (
        clearMemoryCmd && !mission_active_flag && !startMissionCmd
        && !forcedConvDone && !missionConvDone |=>
        memory_cleared_flag && !high_temp_flag && !low_temp_flag)
        else $error("clear did not reset flags");
    start_refused_a: assert property (
        startMissionCmd && !memory_cleared_flag && !mission_active_flag
        |=> !mission_active_flag)
        else $error("start accepted without cleared memory");
    start_effect_a: assert property (
        startMissionCmd && memory_cleared_flag && !mission_active_flag
        && !clearMemoryCmd |=>
        mission_active_flag && !memory_cleared_flag && startAccepted)
        else $error("start did not begin mission");
    stop_effect_a: assert property (
        stopMissionCmd && mission_active_flag && !startMissionCmd
        |=> !mission_active_flag)
        else $error("stop did not end mission");
    await_keep_a: assert property (
        clearMemoryCmd && awaiting_alarm_flag && !forcedConvDone
        && !missionConvDone |=> awaiting_alarm_flag)
        else $error("clear touched awaiting flag");
    high_sticky_a: assert property (
        $fell(high_temp_flag) |-> $past(clearMemoryCmd))
        else $error("high flag dropped without clear");
    high_set_a: assert property (
        forcedConvDone && convHighHit && highAlarmEnable |=> high_temp_flag)
        else $error("high flag not set");
    bor_reset_a: assert property (
        $rose(reset_n) |-> battery_reset_flag)
        else $error("battery flag low after reset");
endmodule : msr_checker

bind msr_mission_status msr_checker i_msr_checker (
    .clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regRdEn(regRdEn),
    .regRdData(regRdData), .clearMemoryCmd(clearMemoryCmd),
    .startMissionCmd(startMissionCmd), .stopMissionCmd(stopMissionCmd),
    .missionConvDone(missionConvDone), .forcedConvDone(forcedConvDone),
    .convHighHit(convHighHit), .highAlarmEnable(highAlarmEnable),
    .mission_active_flag(mission_active_flag),
    .awaiting_alarm_flag(awaiting_alarm_flag),
    .memory_cleared_flag(memory_cleared_flag),
    .battery_reset_flag(battery_reset_flag),
    .high_temp_flag(high_temp_flag), .low_temp_flag(low_temp_flag),
    .startAccepted(startAccepted));

`default_nettype wire

// ===== tb/msr_rtc_model.sv
// Minute timebase and BCD calendar beside the register bank
`default_nettype none

module msr_rtc_model #(
    parameter int TICK_CYCLES = 20
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset_n,
    // Timebase
    output var  logic         minuteTick,
    output var  logic [47:0]  calendarNow
);
    timeunit 1ns;
    timeprecision 1ns;
    int tickCount_q;

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            tickCount_q <= 0;
            minuteTick <= 1'b0;
            calendarNow <= 48'h240115093000;
        end
        else
        begin
            tickCount_q <= (tickCount_q == TICK_CYCLES - 1) ? 0
                           : tickCount_q + 1;
            minuteTick <= (tickCount_q == TICK_CYCLES - 1);
            if (minuteTick)
                calendarNow[11:8] <= (calendarNow[11:8] == 4'h9) ? 4'h0
                                     : calendarNow[11:8] + 4'h1;
        end
    end
endmodule : msr_rtc_model

`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the mission status register bank
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, reset_n = 1'b0, regRdEn = 1'b0, regWrEn = 1'b0;
    logic [15:0] regAddr = 16'h0000;
    logic [7:0]  regWrData = 8'h00;
    logic [4:0]  evt = 5'h00;
    logic        hiHit = 1'b0, loHit = 1'b0, hiEn = 1'b1, loEn = 1'b1;
    logic        sutaSel = 1'b0;
    logic [7:0]  regRdData;
    logic        minuteTick, loggingActive, alarmTesting;
    logic [47:0] calendarNow, lastCal, stamp;
    int          fail_count = 0;
    int          cmp_count = 0;
    int          waited;

    always #10 clk = ~clk;

    msr_rtc_model #(.TICK_CYCLES(10)) i_msr_rtc_model (
        .clk(clk), .reset_n(reset_n), .minuteTick(minuteTick),
        .calendarNow(calendarNow));

    msr_mission_status i_msr_mission_status (
        .clk(clk), .reset_n(reset_n), .regAddr(regAddr),
        .regRdEn(regRdEn), .regWrEn(regWrEn), .regWrData(regWrData),
        .regRdData(regRdData), .clearMemoryCmd(evt[0]),
        .startMissionCmd(evt[1]), .stopMissionCmd(evt[2]),
        .highAlarmEnable(hiEn), .lowAlarmEnable(loEn),
        .alarm_triggered_start(sutaSel), .missionConvDone(evt[3]),
        .forcedConvDone(evt[4]), .convHighHit(hiHit), .convLowHit(loHit),
        .minuteTick(minuteTick), .calendarNow(calendarNow),
        .mission_active_flag(), .awaiting_alarm_flag(),
        .memory_cleared_flag(), .battery_reset_flag(),
        .high_temp_flag(), .low_temp_flag(), .alarmTesting(alarmTesting),
        .loggingActive(loggingActive), .startAccepted());

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run

    task automatic check8(input string what, input logic [7:0] exp,
                          input logic [7:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check8

    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1;
        check8($sformatf("reg %h", a), exp, regRdData);
    endtask : rd

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
    endtask : wr

    // Bits: clear, start, stop, mission conversion, forced conversion
    task automatic pulse(input logic [4:0] e, input logic h, input logic l);
        @(posedge clk);
        evt <= e;
        hiHit <= h;
        loHit <= l;
        @(posedge clk);
        lastCal = calendarNow;
        evt <= 5'h00;
    endtask : pulse

    initial
    begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        rd(16'h0214, 8'hF0);
        rd(16'h0215, 8'hC0);
        rd(16'h0300, 8'h00);
        wr(16'h0214, 8'h00);
        rd(16'h0214, 8'hF0);
        pulse(5'h02, 1'b0, 1'b0);
        rd(16'h0215, 8'hC0);
        pulse(5'h01, 1'b0, 1'b0);
        rd(16'h0214, 8'h70);
        rd(16'h0215, 8'hC8);
        for (int i = 0; i < 3; i++)
            wr(16'h0216 + 16'(i), 8'(8'h02 - i));
        for (int i = 0; i < 3; i++)
            rd(16'h0216 + 16'(i), 8'(8'h02 - i));
        pulse(5'h02, 1'b0, 1'b0);
        waited = 0;
        rd(16'h0215, 8'hC2);
        wr(16'h0216, 8'hFF);
        rd(16'h0216, 8'h02);
        pulse(5'h08, 1'b1, 1'b0);
        rd(16'h0214, 8'h70);
        while (loggingActive !== 1'b1 && waited < 4000)
        begin
            @(posedge clk);
            waited++;
        end
        check8("delay elapsed", 8'h01,
               {7'h00, waited >= 2500 && waited < 2600});
        if (waited >= 4000)
            complete_run();
        pulse(5'h08, 1'b1, 1'b0);
        stamp = lastCal;
        pulse(5'h08, 1'b0, 1'b1);
        rd(16'h0214, 8'h73);
        for (int i = 0; i < 3; i++)
            rd(16'h0220 + 16'(i), i == 0 ? 8'h02 : 8'h00);
        for (int i = 0; i < 6; i++)
            rd(16'h0219 + 16'(i), stamp[8*i +: 8]);
        pulse(5'h04, 1'b0, 1'b0);
        rd(16'h0215, 8'hC0);
        pulse(5'h01, 1'b0, 1'b0);
        rd(16'h0220, 8'h00);
        rd(16'h0214, 8'h70);
        wr(16'h0216, 8'h00);
        wr(16'h0217, 8'h00);
        @(posedge clk);
        sutaSel <= 1'b1;
        pulse(5'h02, 1'b0, 1'b0);
        rd(16'h0215, 8'hD2);
        check8("alarm testing", 8'h01, {7'h00, alarmTesting});
        pulse(5'h04, 1'b0, 1'b0);
        pulse(5'h01, 1'b0, 1'b0);
        rd(16'h0215, 8'hD8);
        @(posedge clk);
        loEn <= 1'b0;
        pulse(5'h10, 1'b0, 1'b1);
        rd(16'h0214, 8'h70);
        pulse(5'h10, 1'b1, 1'b0);
        rd(16'h0215, 8'hC8);
        rd(16'h0214, 8'h72);
        @(posedge clk);
        loEn <= 1'b1;
        pulse(5'h02, 1'b0, 1'b0);
        pulse(5'h08, 1'b0, 1'b1);
        rd(16'h0214, 8'h73);
        rd(16'h0215, 8'hC2);
        rd(16'h0220, 8'h00);
        rd(16'h021A, lastCal[15:8]);
        complete_run();
    end
endmodule : tb

`default_nettype wire
